// ==== design/msc_regs.svh ====
// Constants for the motor drive supervisor and configuration block
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH
// Field widths
`define MSC_VOLT_W 9
`define MSC_CUR_W 8
`define MSC_SPEED_W 8
`define MSC_BEMF_W 8
`define MSC_DIV_W 5
`define MSC_SLEEP_W 24
`define MSC_DECEL_W 4
// Override encodings for direction and brake
`define MSC_OVR_PIN 2'h0
`define MSC_OVR_FORCE_ON 2'h1
`define MSC_OVR_FORCE_OFF 2'h2
// Tacho loop select encodings
`define MSC_TSEL_CLOSED 2'h0
`define MSC_TSEL_BOTH 2'h1
`define MSC_TSEL_OPEN 2'h2
// Single-bit modes
`define MSC_TACHO_WHILE_DRIVEN 1'h0
`define MSC_LP_STANDBY 1'h0
`define MSC_BRAKE_LOW_SIDE 1'h0
`define MSC_MOD_CONTINUOUS 1'h0
`define MSC_REC_AUTO 1'h0
// Supply limit ranges in units of 100 mV
`define MSC_LOW_LIMIT_MIN 9'h02D
`define MSC_LOW_LIMIT_MAX 9'h07D
`define MSC_HIGH_LIMIT_MIN 9'h0C8
`define MSC_HIGH_LIMIT_MAX 9'h15E
// Safe deceleration step used by the surge guard
`define MSC_SAFE_DECEL 4'h1
// Commutation step count
`define MSC_STEP_LAST 3'h5
`define MSC_STEP_FIRST 3'h0
`endif

// ==== design/msc_pkg.sv ====
// Types for the motor drive supervisor and configuration block
`include "msc_regs.svh"
package msc_pkg;
  typedef enum logic [1:0] {
    MSC_LOOP_STOPPED = 2'b00,
    MSC_LOOP_OPEN = 2'b01,
    MSC_LOOP_CLOSED = 2'b10,
    MSC_LOOP_COAST = 2'b11
  } msc_loop_e;

  typedef enum logic [1:0] {
    MSC_PWR_ACTIVE = 2'b00,
    MSC_PWR_STANDBY = 2'b01,
    MSC_PWR_SLEEP = 2'b10
  } msc_pwr_e;

  typedef struct packed {
    logic low_power_state_select;
    logic [1:0] dir_override;
    logic [1:0] brake_override;
    logic brake_pin_mode;
    logic tacho_activity_mode;
    logic [1:0] tacho_loop_select;
    logic [`MSC_DIV_W-1:0] tacho_divider;
    logic [`MSC_BEMF_W-1:0] tacho_backemf_threshold;
    logic modulation_scheme;
    logic bus_current_limit_enable;
    logic [`MSC_CUR_W-1:0] bus_current_limit;
    logic surge_guard_enable;
    logic [`MSC_DECEL_W-1:0] decel_step;
    logic [`MSC_VOLT_W-1:0] supply_low_limit;
    logic [`MSC_VOLT_W-1:0] supply_high_limit;
    logic undervolt_recovery_select;
    logic overvolt_recovery_select;
    logic [`MSC_SPEED_W-1:0] speed_threshold;
    logic [`MSC_SLEEP_W-1:0] sleep_entry_cycles;
  } msc_cfg_s;

  typedef struct packed {
    logic a_hi;
    logic a_lo;
    logic b_hi;
    logic b_lo;
    logic c_hi;
    logic c_lo;
  } msc_gate_s;
endpackage : msc_pkg

// ==== design/msc_supervisor.sv ====
// Supervisor and configuration logic of a three-phase sensorless motor controller
`timescale 1ns/1ns
`default_nettype none
`include "msc_regs.svh"

module msc_supervisor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire msc_pkg::msc_cfg_s cfg,
  input wire logic dir_pin,
  input wire logic brake_pin,
  input wire logic [`MSC_SPEED_W-1:0] speed_in,
  input wire msc_pkg::msc_loop_e loop_state,
  input wire logic comm_tick,
  input wire logic [`MSC_BEMF_W-1:0] backemf_level,
  input wire logic [`MSC_CUR_W-1:0] bus_current,
  input wire logic [`MSC_VOLT_W-1:0] bus_voltage,
  input wire logic fault_clear,
  output msc_pkg::msc_gate_s gates,
  output logic dir_clockwise,
  output logic braking,
  output logic charge_pump_enable,
  output logic analog_supply_regulator,
  output logic serial_bus_enable,
  output msc_pkg::msc_pwr_e power_state,
  output logic tacho_output,
  output logic [`MSC_SPEED_W-1:0] duty_applied,
  output logic current_limit_active,
  output logic undervolt_fault,
  output logic overvolt_fault
);

  // ***************************************************************
  // Functions
  // ***************************************************************
  // Phase driven high in a six-step commutation step (0 A, 1 B, 2 C)
  function automatic logic [1:0] hi_phase(input logic [2:0] step);
    case (step)
      3'h0, 3'h1: hi_phase = 2'h0;
      3'h2, 3'h3: hi_phase = 2'h1;
      default: hi_phase = 2'h2;
    endcase
  endfunction : hi_phase

  // Phase held low in the same step
  function automatic logic [1:0] lo_phase(input logic [2:0] step);
    case (step)
      3'h0, 3'h5: lo_phase = 2'h1;
      3'h1, 3'h2: lo_phase = 2'h2;
      default: lo_phase = 2'h0;
    endcase
  endfunction : lo_phase

  // Clamp a setting into its accepted range
  function automatic logic [`MSC_VOLT_W-1:0] clamp_volt(
    input logic [`MSC_VOLT_W-1:0] v,
    input logic [`MSC_VOLT_W-1:0] lo,
    input logic [`MSC_VOLT_W-1:0] hi
  );
    if (v < lo) begin
      clamp_volt = lo;
    end else if (v > hi) begin
      clamp_volt = hi;
    end else begin
      clamp_volt = v;
    end
  endfunction : clamp_volt

  // ***************************************************************
  // Low-power entry
  // ***************************************************************
  logic [`MSC_SLEEP_W-1:0] slow_cnt_ff;
  logic [`MSC_SLEEP_W-1:0] nxt_slow_cnt;
  msc_pkg::msc_pwr_e pwr_ff;
  msc_pkg::msc_pwr_e nxt_pwr;
  wire logic speed_low = speed_in < cfg.speed_threshold;
  wire logic slow_expired = slow_cnt_ff >= cfg.sleep_entry_cycles;
  wire logic low_power = pwr_ff != msc_pkg::MSC_PWR_ACTIVE;
  wire logic enter_sleep = cfg.low_power_state_select != `MSC_LP_STANDBY;
  // Gates register alongside power_state, so they must see the state being entered
  wire logic nxt_low_power = nxt_pwr != msc_pkg::MSC_PWR_ACTIVE;

  // Any sample at or above threshold restarts the count
  assign nxt_slow_cnt = !speed_low ? '0 : (slow_expired ? slow_cnt_ff : slow_cnt_ff + 1'b1);

  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      msc_pkg::MSC_PWR_ACTIVE: begin
        if (speed_low && slow_expired) begin
          nxt_pwr = enter_sleep ? msc_pkg::MSC_PWR_SLEEP : msc_pkg::MSC_PWR_STANDBY;
        end
      end
      msc_pkg::MSC_PWR_STANDBY, msc_pkg::MSC_PWR_SLEEP: begin
        if (!speed_low) begin
          nxt_pwr = msc_pkg::MSC_PWR_ACTIVE;
        end
      end
      default: nxt_pwr = msc_pkg::MSC_PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slow_cnt_ff <= '0;
      pwr_ff <= msc_pkg::MSC_PWR_ACTIVE;
    end else if (clk_en) begin
      slow_cnt_ff <= nxt_slow_cnt;
      pwr_ff <= nxt_pwr;
    end
  end

  // ***************************************************************
  // Direction and brake selection
  // ***************************************************************
  wire logic dir_cw_sel = (cfg.dir_override == `MSC_OVR_FORCE_ON) ? 1'b1 :
                          (cfg.dir_override == `MSC_OVR_FORCE_OFF) ? 1'b0 :
                          dir_pin;
  wire logic brake_sel = (cfg.brake_override == `MSC_OVR_FORCE_ON) ? 1'b1 :
                         (cfg.brake_override == `MSC_OVR_FORCE_OFF) ? 1'b0 :
                         brake_pin;
  wire logic align_mode = cfg.brake_pin_mode != `MSC_BRAKE_LOW_SIDE;

  // ***************************************************************
  // Speed ramp, current limit and surge guard
  // ***************************************************************
  logic [`MSC_SPEED_W-1:0] duty_ff;
  logic [`MSC_SPEED_W-1:0] nxt_duty;
  wire logic over_current = cfg.bus_current_limit_enable && (bus_current > cfg.bus_current_limit);
  wire logic [`MSC_DECEL_W-1:0] decel_used =
    cfg.surge_guard_enable ? `MSC_SAFE_DECEL : cfg.decel_step;
  wire logic [`MSC_SPEED_W-1:0] decel_ext = {{(`MSC_SPEED_W-`MSC_DECEL_W){1'b0}}, decel_used};
  wire logic [`MSC_SPEED_W-1:0] dec_floor = (duty_ff > decel_ext) ? duty_ff - decel_ext : '0;
  wire logic [`MSC_SPEED_W-1:0] dec_target = (dec_floor < speed_in) ? speed_in : dec_floor;

  always_comb begin
    nxt_duty = duty_ff;
    if (over_current) begin
      // Shed speed one step per cycle until the supply current falls back
      nxt_duty = (duty_ff != '0) ? duty_ff - 1'b1 : duty_ff;
    end else if (speed_in > duty_ff) begin
      nxt_duty = duty_ff + 1'b1;
    end else if (speed_in < duty_ff) begin
      nxt_duty = dec_target;
    end
  end

  // ***************************************************************
  // Supply supervision
  // ***************************************************************
  wire logic [`MSC_VOLT_W-1:0] low_lim =
    clamp_volt(cfg.supply_low_limit, `MSC_LOW_LIMIT_MIN, `MSC_LOW_LIMIT_MAX);
  wire logic [`MSC_VOLT_W-1:0] high_lim =
    clamp_volt(cfg.supply_high_limit, `MSC_HIGH_LIMIT_MIN, `MSC_HIGH_LIMIT_MAX);
  wire logic uv_cond = bus_voltage < low_lim;
  wire logic ov_cond = bus_voltage > high_lim;
  // Condition present always sets; a latched fault waits for an explicit clear
  wire logic uv_auto = cfg.undervolt_recovery_select == `MSC_REC_AUTO;
  wire logic ov_auto = cfg.overvolt_recovery_select == `MSC_REC_AUTO;
  wire logic nxt_uv = uv_cond || (undervolt_fault && !uv_auto && !fault_clear);
  wire logic nxt_ov = ov_cond || (overvolt_fault && !ov_auto && !fault_clear);
  wire logic fault_any = undervolt_fault || overvolt_fault;

  // ***************************************************************
  // Commutation and PWM
  // ***************************************************************
  logic [2:0] step_ff;
  logic [2:0] nxt_step;
  logic [`MSC_SPEED_W-1:0] carrier_ff;
  wire logic driving = (loop_state == msc_pkg::MSC_LOOP_OPEN) ||
                       (loop_state == msc_pkg::MSC_LOOP_CLOSED);
  wire logic run_ok = driving && !low_power && !fault_any;
  wire logic pwm_on = carrier_ff < duty_ff;
  wire logic svm_cont = cfg.modulation_scheme == `MSC_MOD_CONTINUOUS;

  // Clockwise walks steps upward (A, B, C peaks); anti-clockwise walks down (A, C, B)
  always_comb begin
    nxt_step = step_ff;
    if (comm_tick && run_ok) begin
      if (dir_cw_sel) begin
        nxt_step = (step_ff == `MSC_STEP_LAST) ? `MSC_STEP_FIRST : step_ff + 1'b1;
      end else begin
        nxt_step = (step_ff == `MSC_STEP_FIRST) ? `MSC_STEP_LAST : step_ff - 1'b1;
      end
    end
  end

  logic [2:0] hi_vec;
  logic [2:0] lo_vec;
  wire logic [1:0] hp = hi_phase(step_ff);
  wire logic [1:0] lp = lo_phase(step_ff);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      wire logic is_hi = hp == 2'(gi);
      wire logic is_lo = lp == 2'(gi);
      always_comb begin
        hi_vec[gi] = 1'b0;
        lo_vec[gi] = 1'b0;
        if (low_power || nxt_low_power || fault_any) begin
          hi_vec[gi] = 1'b0;
          lo_vec[gi] = 1'b0;
        end else if (brake_sel && !align_mode) begin
          lo_vec[gi] = 1'b1;
        end else if (brake_sel) begin
          // Phase A sources, B and C sink: a fixed DC vector holds the rotor
          hi_vec[gi] = (gi == 0) && pwm_on;
          lo_vec[gi] = (gi != 0);
        end else if (run_ok) begin
          hi_vec[gi] = is_hi && pwm_on;
          // Continuous keeps the clamped leg switching complementary; discontinuous
          // parks it on to save switching losses at the cost of current ripple
          lo_vec[gi] = is_lo && (svm_cont ? !pwm_on : 1'b1);
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Tacho output
  // ***************************************************************
  logic [`MSC_DIV_W-1:0] tdiv_ff;
  logic tacho_ff;
  wire logic loop_ok =
    (cfg.tacho_loop_select == `MSC_TSEL_BOTH) ? driving :
    (cfg.tacho_loop_select == `MSC_TSEL_OPEN) ? (loop_state == msc_pkg::MSC_LOOP_OPEN) :
    (loop_state == msc_pkg::MSC_LOOP_CLOSED);
  wire logic bemf_ok = backemf_level >= cfg.tacho_backemf_threshold;
  wire logic tacho_run = (cfg.tacho_activity_mode == `MSC_TACHO_WHILE_DRIVEN) ?
                         (loop_ok && run_ok) :
                         ((loop_ok || !driving) && bemf_ok && !low_power);
  // A divider of zero is treated as one so the output never stalls
  wire logic div_wrap = (tdiv_ff + 1'b1 >= cfg.tacho_divider);
  wire logic [`MSC_DIV_W-1:0] nxt_tdiv = div_wrap ? '0 : tdiv_ff + 1'b1;
  wire logic nxt_tacho = !tacho_run ? (low_power ? 1'b1 : 1'b0) :
                         ((comm_tick && div_wrap) ? !tacho_ff : tacho_ff);

  // ***************************************************************
  // State registers and output flops
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      duty_ff <= '0;
      step_ff <= `MSC_STEP_FIRST;
      carrier_ff <= '0;
      tdiv_ff <= '0;
      tacho_ff <= 1'b0;
    end else if (clk_en) begin
      duty_ff <= nxt_duty;
      step_ff <= nxt_step;
      carrier_ff <= carrier_ff + 1'b1;
      tdiv_ff <= (comm_tick && tacho_run) ? nxt_tdiv : tdiv_ff;
      tacho_ff <= nxt_tacho;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gates <= '0;
      dir_clockwise <= 1'b1;
      braking <= 1'b0;
      charge_pump_enable <= 1'b1;
      analog_supply_regulator <= 1'b1;
      serial_bus_enable <= 1'b1;
      power_state <= msc_pkg::MSC_PWR_ACTIVE;
      tacho_output <= 1'b0;
      duty_applied <= '0;
      current_limit_active <= 1'b0;
      undervolt_fault <= 1'b0;
      overvolt_fault <= 1'b0;
    end else if (clk_en) begin
      gates <= '{a_hi: hi_vec[0], a_lo: lo_vec[0], b_hi: hi_vec[1],
                 b_lo: lo_vec[1], c_hi: hi_vec[2], c_lo: lo_vec[2]};
      dir_clockwise <= dir_cw_sel;
      braking <= brake_sel && !low_power;
      // Standby keeps supplies and the bus alive; only sleep shuts them down
      charge_pump_enable <= nxt_pwr != msc_pkg::MSC_PWR_SLEEP;
      analog_supply_regulator <= nxt_pwr != msc_pkg::MSC_PWR_SLEEP;
      serial_bus_enable <= nxt_pwr != msc_pkg::MSC_PWR_SLEEP;
      power_state <= nxt_pwr;
      tacho_output <= nxt_tacho;
      duty_applied <= nxt_duty;
      current_limit_active <= over_current;
      undervolt_fault <= nxt_uv;
      overvolt_fault <= nxt_ov;
    end
  end

endmodule : msc_supervisor
`default_nettype wire

// ==== verif/msc_motor_model.sv ====
// Motor stand-in: commutation ticks and back-EMF driven by the gate pattern
`timescale 1ns/1ns
`default_nettype none
`include "msc_regs.svh"
module msc_motor_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire msc_pkg::msc_gate_s gates,
  input wire logic [3:0] tick_period,
  output logic comm_tick,
  output logic [`MSC_BEMF_W-1:0] backemf_level
);
  // ****
  // Rotor
  // ****
  logic [3:0] phase_ff;
  logic tick_ff;
  logic [`MSC_BEMF_W-1:0] emf_ff;
  logic driven;
  logic wrap;
  assign driven = gates.a_hi | gates.b_hi | gates.c_hi;
  assign wrap = phase_ff >= tick_period;
  assign comm_tick = tick_ff;
  assign backemf_level = emf_ff;
  // A coasting rotor keeps ticking until its back-EMF has decayed to zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_ff <= 4'h0;
      tick_ff <= 1'b0;
      emf_ff <= 8'h00;
    end else begin
      phase_ff <= wrap ? 4'h0 : phase_ff + 4'h1;
      tick_ff <= wrap && (emf_ff != 8'h00);
      emf_ff <= driven ? emf_ff + {7'h0, emf_ff != 8'hFF} : emf_ff - {7'h0, emf_ff != 8'h00};
    end
  end
endmodule : msc_motor_model
`default_nettype wire

// ==== verif/msc_supervisor_checker.sv ====
// Port assertions for the motor drive supervisor
`timescale 1ns/1ns
`default_nettype none
`include "msc_regs.svh"
module msc_supervisor_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire msc_pkg::msc_cfg_s cfg,
  input wire logic dir_pin,
  input wire logic [`MSC_SPEED_W-1:0] speed_in,
  input wire logic [`MSC_CUR_W-1:0] bus_current,
  input wire logic [`MSC_VOLT_W-1:0] bus_voltage,
  input wire logic fault_clear,
  input wire msc_pkg::msc_gate_s gates,
  input wire logic dir_clockwise,
  input wire logic braking,
  input wire logic charge_pump_enable,
  input wire logic analog_supply_regulator,
  input wire logic serial_bus_enable,
  input wire msc_pkg::msc_pwr_e power_state,
  input wire logic tacho_output,
  input wire logic [`MSC_SPEED_W-1:0] duty_applied,
  input wire logic undervolt_fault,
  input wire logic overvolt_fault
);
  // ****
  // Clamped limits
  // ****
  logic [`MSC_VOLT_W-1:0] lo_lim;
  logic [`MSC_VOLT_W-1:0] hi_lim;
  logic v_ok;
  logic slow;
  assign lo_lim = (cfg.supply_low_limit < `MSC_LOW_LIMIT_MIN) ? `MSC_LOW_LIMIT_MIN
    : (cfg.supply_low_limit > `MSC_LOW_LIMIT_MAX) ? `MSC_LOW_LIMIT_MAX : cfg.supply_low_limit;
  assign hi_lim = (cfg.supply_high_limit < `MSC_HIGH_LIMIT_MIN) ? `MSC_HIGH_LIMIT_MIN
    : (cfg.supply_high_limit > `MSC_HIGH_LIMIT_MAX) ? `MSC_HIGH_LIMIT_MAX : cfg.supply_high_limit;
  assign v_ok = (bus_voltage >= lo_lim) && (bus_voltage <= hi_lim);
  assign slow = speed_in < cfg.speed_threshold;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // Assertions
  // ****
  a_uv_set: assert property (clk_en && bus_voltage < lo_lim |=> undervolt_fault)
    else $error("undervolt fault not raised");
  a_ov_set: assert property (clk_en && bus_voltage > hi_lim |=> overvolt_fault)
    else $error("overvolt fault not raised");
  a_uv_auto_clear: assert property (clk_en && !cfg.undervolt_recovery_select && !(bus_voltage < lo_lim)
    |=> !undervolt_fault) else $error("undervolt fault did not clear");
  a_ov_latch_hold: assert property (clk_en && overvolt_fault && cfg.overvolt_recovery_select
    && !fault_clear |=> overvolt_fault) else $error("latched overvolt fault dropped");
  a_sleep_all_off: assert property (power_state == msc_pkg::MSC_PWR_SLEEP |-> gates == 6'h00
    && !charge_pump_enable && !analog_supply_regulator && !serial_bus_enable)
    else $error("supply or outputs on in sleep");
  a_dir_force_cw: assert property (clk_en && cfg.dir_override == `MSC_OVR_FORCE_ON
    |=> dir_clockwise) else $error("forced clockwise ignored");
  a_dir_from_pin: assert property (clk_en && cfg.dir_override == `MSC_OVR_PIN
    |=> dir_clockwise == $past(dir_pin)) else $error("direction pin not followed");
  a_lowside_brake: assert property ((clk_en && cfg.brake_override == `MSC_OVR_FORCE_ON
    && cfg.brake_pin_mode == `MSC_BRAKE_LOW_SIDE && v_ok && !slow && !undervolt_fault
    && !overvolt_fault)[*2] |=> gates == 6'h15) else $error("low-side brake pattern wrong");
  a_brake_forced_off: assert property ((clk_en && cfg.brake_override == `MSC_OVR_FORCE_OFF)[*2]
    |=> !braking) else $error("brake applied while forced off");
  a_tacho_low_power: assert property (clk_en && power_state != msc_pkg::MSC_PWR_ACTIVE && slow
    |=> tacho_output) else $error("tacho not released high in low power");
  a_current_hold: assert property ((clk_en && cfg.bus_current_limit_enable
    && bus_current > cfg.bus_current_limit)[*2] |=> duty_applied <= $past(duty_applied))
    else $error("duty rose while over current");
  a_reset_state: assert property (disable iff (1'b0) sys_rst && clk_en |=> gates == 6'h00
    && dir_clockwise && !braking && power_state == msc_pkg::MSC_PWR_ACTIVE && !tacho_output
    && duty_applied == 8'h00 && !undervolt_fault && !overvolt_fault) else $error("bad reset state");
endmodule : msc_supervisor_checker
bind msc_supervisor msc_supervisor_checker u_msc_supervisor_checker (.clk, .sys_rst, .clk_en,
  .cfg, .dir_pin, .speed_in, .bus_current, .bus_voltage, .fault_clear, .gates, .dir_clockwise,
  .braking, .charge_pump_enable, .analog_supply_regulator, .serial_bus_enable, .power_state,
  .tacho_output, .duty_applied, .undervolt_fault, .overvolt_fault);
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the motor drive supervisor
`timescale 1ns/1ns
`default_nettype none
`include "msc_regs.svh"
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic dir_pin = 1'b0;
  logic brake_pin = 1'b0;
  logic fault_clear = 1'b0;
  logic comm_tick;
  msc_pkg::msc_cfg_s cfg;
  msc_pkg::msc_loop_e loop_state = msc_pkg::MSC_LOOP_CLOSED;
  logic [`MSC_SPEED_W-1:0] speed_in = 8'h40;
  logic [`MSC_BEMF_W-1:0] backemf_level;
  logic [`MSC_CUR_W-1:0] bus_current = 8'h00;
  logic [`MSC_VOLT_W-1:0] bus_voltage = 9'h0C8;
  logic [3:0] tick_period = 4'h3;
  msc_pkg::msc_gate_s gates;
  msc_pkg::msc_pwr_e power_state;
  logic dir_clockwise, braking, charge_pump_enable, analog_supply_regulator, serial_bus_enable;
  logic tacho_output, current_limit_active, undervolt_fault, overvolt_fault;
  logic [`MSC_SPEED_W-1:0] duty_applied;
  logic chk_on = 1'b0;
  logic [31:0] lfsr = 32'hA2C32A9B;
  int miscompares = 0;
  int checked = 0;
  int cnt, e_pwr, e_uv, e_ov, lo, hi;
  always #5 clk = ~clk;
  msc_supervisor u_msc_supervisor (.clk, .sys_rst, .clk_en, .cfg, .dir_pin, .brake_pin, .speed_in,
    .loop_state, .comm_tick, .backemf_level, .bus_current, .bus_voltage, .fault_clear, .gates,
    .dir_clockwise, .braking, .charge_pump_enable, .analog_supply_regulator, .serial_bus_enable,
    .power_state, .tacho_output, .duty_applied, .current_limit_active, .undervolt_fault,
    .overvolt_fault);
  msc_motor_model u_msc_motor_model (.clk, .sys_rst, .gates, .tick_period, .comm_tick,
    .backemf_level);
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  function automatic int clamp(input int v, input int a, input int b);
    return (v < a) ? a : ((v > b) ? b : v);
  endfunction : clamp
  task automatic cmp_val(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_val
  task automatic cmp_pwr(input string n, input int e, input msc_pkg::msc_pwr_e g);
    checked++;
    if (g !== e[1:0]) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask : cmp_pwr
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // ****
  // Reference model of faults and power state
  // ****
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt = 0;
      e_pwr = 0;
      e_uv = 0;
      e_ov = 0;
    end else if (clk_en) begin
      lo = clamp(cfg.supply_low_limit, `MSC_LOW_LIMIT_MIN, `MSC_LOW_LIMIT_MAX);
      hi = clamp(cfg.supply_high_limit, `MSC_HIGH_LIMIT_MIN, `MSC_HIGH_LIMIT_MAX);
      e_uv = (bus_voltage < lo) || (e_uv && cfg.undervolt_recovery_select && !fault_clear);
      e_ov = (bus_voltage > hi) || (e_ov && cfg.overvolt_recovery_select && !fault_clear);
      if (speed_in >= cfg.speed_threshold) begin
        cnt = 0;
        e_pwr = 0;
      end else if (cnt == cfg.sleep_entry_cycles) begin
        // The low-power kind is chosen on entry and kept until speed returns
        if (e_pwr == 0) e_pwr = cfg.low_power_state_select ? 2 : 1;
      end else cnt++;
    end
  end
  always @(negedge clk) begin
    if (chk_on) begin
      cmp_val("undervolt_fault", 8'(e_uv), {7'h0, undervolt_fault});
      cmp_val("overvolt_fault", 8'(e_ov), {7'h0, overvolt_fault});
      cmp_pwr("power_state", e_pwr, power_state);
      cmp_val("supply_enables", (e_pwr == 2) ? 8'h00 : 8'h07, {5'h0, charge_pump_enable, analog_supply_regulator, serial_bus_enable});
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    cfg = '0;
    cfg.low_power_state_select = 1'b1;
    cfg.tacho_divider = 5'h02;
    cfg.tacho_backemf_threshold = 8'h04;
    cfg.bus_current_limit = 8'h80;
    cfg.decel_step = 4'h2;
    cfg.supply_low_limit = 9'h064;
    cfg.supply_high_limit = 9'h12C;
    cfg.speed_threshold = 8'h0A;
    cfg.sleep_entry_cycles = 24'h000002;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    chk_on <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      cfg.dir_override <= c[2:1];
      dir_pin <= c[0];
      settle(2);
      cmp_val("dir_clockwise", (c[2:1] == 2'h1) ? 8'h01 : (c[2:1] == 2'h2) ? 8'h00 : 8'(c[0]), {7'h0, dir_clockwise});
    end
    @(posedge clk);
    cfg.brake_override <= `MSC_OVR_FORCE_ON;
    settle(3);
    cmp_val("braking", 8'h01, {7'h0, braking});
    cmp_val("lowside_gates", 8'h15, {2'h0, gates});
    @(posedge clk);
    cfg.brake_pin_mode <= 1'b1;
    settle(3);
    cmp_val("align_sinks", 8'h03, {6'h0, gates.b_lo, gates.c_lo});
    @(posedge clk);
    cfg.brake_override <= `MSC_OVR_FORCE_OFF;
    brake_pin <= 1'b1;
    settle(3);
    cmp_val("brake_forced_off", 8'h00, {7'h0, braking});
    // Random traffic: supply, speed and overrides move every cycle, the supply limits every 50th
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      lfsr = lfsr_next(lfsr);
      bus_voltage <= lfsr[8:0];
      speed_in <= {4'h0, lfsr[12:9]};
      clk_en <= lfsr[15:13] != 3'h0;
      fault_clear <= lfsr[16];
      bus_current <= lfsr[24:17];
      dir_pin <= lfsr[25];
      brake_pin <= lfsr[26];
      cfg.undervolt_recovery_select <= lfsr[27];
      cfg.overvolt_recovery_select <= lfsr[28];
      cfg.bus_current_limit_enable <= lfsr[29];
      cfg.dir_override <= lfsr[31:30];
      cfg.brake_override <= lfsr[3:2];
      cfg.brake_pin_mode <= lfsr[4];
      cfg.tacho_activity_mode <= lfsr[5];
      cfg.modulation_scheme <= lfsr[6];
      cfg.surge_guard_enable <= lfsr[7];
      cfg.tacho_loop_select <= lfsr[11:10];
      loop_state <= msc_pkg::msc_loop_e'(lfsr[19:18]);
      tick_period <= lfsr[23:20];
      if (i % 50 == 0) begin
        cfg.supply_low_limit <= {2'h0, lfsr[6:0]};
        cfg.supply_high_limit <= 9'h0B4 + {1'b0, lfsr[14:7]};
      end
    end
    @(posedge clk);
    clk_en <= 1'b1;
    speed_in <= 8'h40;
    settle(2);
    @(posedge clk);
    cfg.low_power_state_select <= 1'b0;
    speed_in <= 8'h05;
    settle(6);
    cmp_pwr("standby", 1, power_state);
    @(posedge clk);
    speed_in <= 8'h40;
    settle(3);
    print_verdict();
  end
  // The run needs about 500 cycles; twenty times that means a hang
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
